/* File: rtl/pmbti_pkg.sv */
package pmbti_pkg;
  // Clock and timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int TOUT_MS      = 25;
  localparam int TOUT_CYC     = CLK_HZ / 1000 * TOUT_MS;
  localparam int STRETCH_CYC  = 4;
  localparam int INIT_CYC     = 16;
  localparam int NSRC         = 8;

  // Command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ONOFF     = 8'h02;
  localparam logic [7:0] CMD_CLRF      = 8'h03;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_STATUS    = 8'h78;
  localparam logic [7:0] CMD_RD_VIN    = 8'h88;
  localparam logic [7:0] CMD_RD_VOUT   = 8'h8b;
  localparam logic [7:0] CMD_RD_IOUT   = 8'h8c;
  localparam logic [7:0] CMD_RD_TEMP2  = 8'h8e;
  localparam logic [7:0] CMD_RD_FREQ   = 8'h95;

  // Reset values and fields
  localparam logic [7:0] ONOFF_DEF = 8'h16;
  localparam logic [7:0] OP_DEF    = 8'h00;
  localparam logic [7:0] VMODE_DEF = 8'h14;
  localparam logic [6:0] ADDR_ZERO = 7'h40;
  localparam int ONOFF_PU  = 4;
  localparam int ONOFF_CMD = 3;
  localparam int ONOFF_CP  = 2;
  localparam int ONOFF_POL = 1;
  localparam int OP_ON     = 7;
  localparam logic [4:0] VOUT_FRAC = 5'h10;

  // LINEAR exponents of telemetry words
  localparam logic [4:0] EXP_IOUT = 5'h1e;
  localparam logic [4:0] EXP_VIN  = 5'h1e;
  localparam logic [4:0] EXP_TEMP = 5'h00;
  localparam logic [4:0] EXP_FREQ = 5'h00;

  // Register byte offsets
  localparam logic [7:0] REG_ALERT_EN = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_ADDR     = 8'h08;
  localparam logic [7:0] REG_ONOFF    = 8'h0c;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_RACK = 5'h04,
    ST_TX   = 5'h08,
    ST_TACK = 5'h10
  } pmbti_state_t;
endpackage

/* File: rtl/pmbti_sync.sv */
module pmbti_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Two-stage synchroniser
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

/* File: rtl/pmbti_crc8.sv */
module pmbti_crc8 (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] din,
  output logic      [7:0] crc
);
  logic [7:0] crc_next;

  // CRC-8, polynomial x8+x2+x+1, MSB first
  always_comb begin
    crc_next = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      crc_next = crc_next[7] ? ((crc_next << 1) ^ 8'h07) : (crc_next << 1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      crc <= 8'h00;
    end else if (clr) begin
      crc <= 8'h00;
    end else if (en) begin
      crc <= crc_next;
    end
  end
endmodule

/* File: rtl/pmbti_top.sv */
// Overview of operation
// - Packet error code checked and appended
// - Target stretches clock after each byte it acks
// - Alert line pulled low on new status
// - All alert sources enabled after reset
// - Per-source alert enable masks the line
// - Default: enable pin alone controls conversion
// - ON_OFF_CONFIG selects on/off source
// - READ_IOUT returns filtered average current
// - READ_VOUT, READ_VIN return measured voltages
// - READ_TEMPERATURE_2 returns controller die temperature
// - READ_FREQUENCY returns switching frequency in kHz
// - Telemetry except READ_VOUT encoded as LINEAR words
// - Output voltage follows VOUT_MODE exponent
// - Full protocol to 100kHz, 400kHz allowed
// - Answers only its own 7-bit address
// - Strap codes sensed at init pick address
// - Strap sensing active only during init
// - Warnings flag only; faults also trip off
module pmbti_top import pmbti_pkg::*; #(
  parameter int          TOUT      = TOUT_CYC,
  parameter int          IOUT_K    = 4,
  parameter logic [7:0]  FAULT_SEL = 8'h0f
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             alert_out_line_out,
  output logic             alert_out_line_oe,
  input  wire logic        enable_pin_in,
  input  wire logic [2:0]  address_strap_pins_hi,
  input  wire logic [3:0]  address_strap_pins_lo,
  output logic             strap_sense_en,
  input  wire logic [7:0]  evt_in,
  input  wire logic        iout_stb,
  input  wire logic [10:0] meas_iout,
  input  wire logic [15:0] meas_vout,
  input  wire logic [10:0] meas_vin,
  input  wire logic [10:0] meas_temp,
  input  wire logic [10:0] meas_freq_khz,
  output logic             conv_on
);
  localparam int AW = 11 + IOUT_K;

  pmbti_state_t st_reg;
  logic [9:0]  pin_s;
  logic        scl_s, sda_s, scl_d, sda_d, en_s;
  logic [3:0]  bit_cnt_reg, str_cnt_reg;
  logic [2:0]  byte_cnt_reg;
  logic [1:0]  tx_idx_reg;
  logic [7:0]  sh_reg, cmd_reg, d0_reg, crc;
  logic        rd_reg, mack_reg;
  logic [31:0] to_cnt_reg;
  logic [4:0]  init_cnt_reg;
  logic        init_busy;
  logic [6:0]  my_addr_reg;
  logic [7:0]  status_reg, alert_en_reg, onoff_reg, op_reg, vmode_reg;
  logic [AW-1:0] iacc_reg;
  logic        wr_ph_reg;
  logic [7:0]  wr_addr_reg;

  // Pin synchronisers and edge history
  pmbti_sync #(.W(10)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({scl_in, sda_in, enable_pin_in, address_strap_pins_hi,
            address_strap_pins_lo}),
    .q    (pin_s)
  );
  assign scl_s = pin_s[9];
  assign sda_s = pin_s[8];
  assign en_s  = pin_s[7];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus condition decode
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s & ~init_busy;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  wire is_idle   = (st_reg == ST_IDLE);
  wire byte_done = (st_reg == ST_RX) & scl_fall & (bit_cnt_reg == 4'h8);
  wire addr_hit  = (sh_reg[7:1] == my_addr_reg);
  wire to_hit    = ~is_idle & (to_cnt_reg >= 32'(TOUT - 1));

  // Init window and address latch
  assign init_busy = (init_cnt_reg != 5'(INIT_CYC));
  assign strap_sense_en = init_busy;
  wire [6:0] strap_addr = (pin_s[6:0] == 7'h00) ? ADDR_ZERO : pin_s[6:0];
  wire init_last = (init_cnt_reg == 5'(INIT_CYC - 1));

  // address picked once at init end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      init_cnt_reg <= 5'h00;
      my_addr_reg  <= ADDR_ZERO;
    end else if (init_busy) begin
      init_cnt_reg <= init_cnt_reg + 5'h01;
      if (init_last) my_addr_reg <= strap_addr;
    end
  end

  // Write length check, PEC optional
  wire cmd_byte = (cmd_reg == CMD_OPERATION) | (cmd_reg == CMD_ONOFF) |
                  (cmd_reg == CMD_VOUT_MODE);
  wire [2:0] need = (cmd_reg == CMD_CLRF) ? 3'h2 :
                    cmd_byte ? 3'h3 : 3'h7;
  // PEC byte must leave residue zero
  wire len_ok = (byte_cnt_reg == need) |
                ((byte_cnt_reg == need + 3'h1) & (crc == 8'h00));
  wire commit = bus_stop & ~rd_reg & (st_reg == ST_RX) &
                (bit_cnt_reg == 4'h1) & len_ok;
  wire clr_flt = commit & (cmd_reg == CMD_CLRF);

  // Telemetry words
  wire [15:0] iout_avg = 16'(iacc_reg >> IOUT_K);
  wire [4:0]  vneg  = 5'h00 - vmode_reg[4:0];
  // scale raw voltage to VOUT_MODE exponent
  wire [4:0]  vsh   = VOUT_FRAC - vneg;
  wire [15:0] vout_w = meas_vout >> vsh;
  logic [15:0] resp;
  logic        resp_two;
  always_comb begin
    resp_two = 1'b1;
    unique case (cmd_reg)
      CMD_RD_IOUT:  resp = {EXP_IOUT, iout_avg[10:0]};
      CMD_RD_VOUT:  resp = vout_w;
      CMD_RD_VIN:   resp = {EXP_VIN, meas_vin};
      CMD_RD_TEMP2: resp = {EXP_TEMP, meas_temp};
      CMD_RD_FREQ:  resp = {EXP_FREQ, meas_freq_khz};
      default: begin
        resp_two = 1'b0;
        resp = (cmd_reg == CMD_OPERATION) ? {8'h00, op_reg} :
               (cmd_reg == CMD_ONOFF) ? {8'h00, onoff_reg} :
               (cmd_reg == CMD_VOUT_MODE) ? {8'h00, vmode_reg} :
               {8'h00, status_reg};
      end
    endcase
  end
  wire [1:0] pec_idx = resp_two ? 2'h2 : 2'h1;
  wire [7:0] tx_byte = (tx_idx_reg == 2'h0) ? resp[7:0] :
                       (tx_idx_reg == pec_idx) ? crc :
                       (tx_idx_reg == 2'h1) ? resp[15:8] : 8'hff;
  wire tx_load = ((st_reg == ST_RACK) & rd_reg) | (st_reg == ST_TACK);
  wire load_now = scl_fall & tx_load & (str_cnt_reg == 4'h0) &
                  ((st_reg == ST_RACK) | mack_reg);

  pmbti_crc8 u_crc (
    .mclk (mclk),
    .nrst (nrst),
    .clr  (bus_start & is_idle),
    .en   (byte_done | load_now),
    .din  (byte_done ? sh_reg : tx_byte),
    .crc  (crc)
  );

  // Clock-low timer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) to_cnt_reg <= 32'h0;
    else if (scl_s | is_idle) to_cnt_reg <= 32'h0;
    else to_cnt_reg <= to_cnt_reg + 32'h1;
  end

  // Target protocol engine
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      tx_idx_reg <= 2'h0;
      str_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      d0_reg <= 8'h00;
      rd_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (to_hit | bus_stop) begin
      st_reg <= ST_IDLE;
      str_cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      st_reg <= ST_RX;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      rd_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: sda_oe <= 1'b0;
        ST_RX: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done) begin
            if (byte_cnt_reg == 3'h0 && !addr_hit) begin
              st_reg <= ST_IDLE;
            end else begin
              st_reg <= ST_RACK;
              str_cnt_reg <= 4'(STRETCH_CYC);
              sda_oe <= 1'b1;
            end
            if (byte_cnt_reg == 3'h0) rd_reg <= sh_reg[0];
            if (byte_cnt_reg == 3'h1) cmd_reg <= sh_reg;
            if (byte_cnt_reg == 3'h2) d0_reg <= sh_reg;
            if (byte_cnt_reg != 3'h7) byte_cnt_reg <= byte_cnt_reg + 3'h1;
            tx_idx_reg <= 2'h0;
          end
        end
        ST_RACK: begin
          if (str_cnt_reg != 4'h0) str_cnt_reg <= str_cnt_reg - 4'h1;
          if (load_now) begin
            st_reg <= ST_TX;
            sh_reg <= tx_byte;
            sda_oe <= ~tx_byte[7];
            bit_cnt_reg <= 4'h0;
            tx_idx_reg <= tx_idx_reg + 2'h1;
          end else if (scl_fall && str_cnt_reg == 4'h0) begin
            st_reg <= ST_RX;
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            sh_reg <= {sh_reg[6:0], 1'b1};
            sda_oe <= (bit_cnt_reg == 4'h7) ? 1'b0 : ~sh_reg[6];
            if (bit_cnt_reg == 4'h7) st_reg <= ST_TACK;
          end
        end
        ST_TACK: begin
          if (scl_rise) mack_reg <= ~sda_s;
          if (load_now) begin
            st_reg <= ST_TX;
            sh_reg <= tx_byte;
            sda_oe <= ~tx_byte[7];
            bit_cnt_reg <= 4'h0;
            if (tx_idx_reg != 2'h3) tx_idx_reg <= tx_idx_reg + 2'h1;
          end else if (scl_fall) begin
            st_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign scl_oe  = (st_reg == ST_RACK) & (str_cnt_reg != 4'h0);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // command register writes from the bus
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_reg    <= OP_DEF;
      onoff_reg <= ONOFF_DEF;
      vmode_reg <= VMODE_DEF;
    end else if (commit) begin
      if (cmd_reg == CMD_OPERATION) op_reg <= d0_reg;
      if (cmd_reg == CMD_ONOFF) onoff_reg <= d0_reg;
      if (cmd_reg == CMD_VOUT_MODE) vmode_reg <= d0_reg;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) status_reg <= 8'h00;
    else status_reg <= (status_reg & ~{NSRC{clr_flt}}) | evt_in;
  end

  assign alert_out_line_oe  = |(status_reg & alert_en_reg);
  assign alert_out_line_out = 1'b0;

  wire pin_ok = en_s == onoff_reg[ONOFF_POL];
  wire run_req = ~onoff_reg[ONOFF_PU] |
                 ((~onoff_reg[ONOFF_CMD] | op_reg[OP_ON]) &
                  (~onoff_reg[ONOFF_CP] | pin_ok));
  wire fault_trip = |(status_reg & FAULT_SEL);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iacc_reg <= '0;
      conv_on  <= 1'b0;
    end else begin
      conv_on <= run_req & ~fault_trip;
      if (iout_stb) iacc_reg <= iacc_reg - (iacc_reg >> IOUT_K) +
                                AW'(meas_iout);
    end
  end

  // AHB-Lite slave, zero wait states
  wire ahb_acc = hsel & hready & htrans[1];
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == REG_ALERT_EN) ? {24'h0, alert_en_reg} :
    (ra == REG_STATUS)   ? {24'h0, status_reg} :
    (ra == REG_ADDR)     ? {24'h0, init_busy, my_addr_reg} :
    (ra == REG_ONOFF)    ? {15'h0, conv_on, op_reg, onoff_reg} : 32'h0;

  // all alert sources enabled from reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ph_reg    <= 1'b0;
      wr_addr_reg  <= 8'h00;
      hrdata       <= 32'h0;
      alert_en_reg <= 8'hff;
    end else begin
      wr_ph_reg <= ahb_acc & hwrite;
      if (ahb_acc) wr_addr_reg <= ra;
      if (ahb_acc & ~hwrite) hrdata <= rd_mux;
      if (wr_ph_reg && wr_addr_reg == REG_ALERT_EN)
        alert_en_reg <= hwdata[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Checks
  sequence s_stretch;
    scl_oe [*4];
  endsequence
  sequence s_quiet;
    !sda_oe [*3];
  endsequence

  a_alert_default: assert property (@(posedge mclk) disable iff (!nrst)
    (init_cnt_reg == 5'h00) |-> (alert_en_reg == 8'hff))
    else $error("alert enables not all set after reset");
  a_alert_set: assert property (@(posedge mclk) disable iff (!nrst)
    (|(evt_in & alert_en_reg)) |=> alert_out_line_oe)
    else $error("enabled event did not pull alert");
  a_alert_mask: assert property (@(posedge mclk) disable iff (!nrst)
    ((status_reg & alert_en_reg) == 8'h00) |-> !alert_out_line_oe)
    else $error("masked source drove alert");
  a_pin_ctrl: assert property (@(posedge mclk) disable iff (!nrst)
    (onoff_reg == ONOFF_DEF && !fault_trip) |=> (conv_on == $past(en_s)))
    else $error("default on/off not following enable pin");
  a_fault_off: assert property (@(posedge mclk) disable iff (!nrst)
    fault_trip |=> !conv_on)
    else $error("fault did not stop conversion");
  a_addr_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (!init_busy && $past(!init_busy)) |-> $stable(my_addr_reg))
    else $error("address changed after init");
  a_sense_window: assert property (@(posedge mclk) disable iff (!nrst)
    (init_cnt_reg == 5'(INIT_CYC)) |-> !strap_sense_en)
    else $error("strap sensing active after init");
  a_timeout_drop: assert property (@(posedge mclk) disable iff (!nrst)
    to_hit |=> (is_idle && !sda_oe && !scl_oe))
    else $error("timeout did not release bus");
  a_foreign_addr: assert property (@(posedge mclk) disable iff (!nrst)
    (byte_done && byte_cnt_reg == 3'h0 && !addr_hit) |=> s_quiet)
    else $error("answered a foreign address");
  a_stretch_byte: assert property (@(posedge mclk) disable iff (!nrst)
    (byte_done && (byte_cnt_reg != 3'h0 || addr_hit) && !bus_stop)
      |=> s_stretch)
    else $error("no clock stretch after byte");
endmodule

/* File: verification/pmbti_host_model.sv */
module pmbti_host_model (
  input  wire logic mclk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output wire logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  logic scl_lo;
  logic sda_lo;

  // Host starts with both lines released
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  // Open-drain lines with pull-ups
  assign scl = ~(scl_lo | scl_oe);
  assign sda = ~(sda_lo | sda_oe);

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic rise();
    int k;
    k = 0;
    scl_lo <= 1'b0;
    do begin
      @(posedge mclk);
      k++;
    end while (scl !== 1'b1 && k < 400);
    tick(3);
  endtask

  // Data set 200 ns before clock release
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_lo <= ~b;
    tick(2);
    rise();
    s = sda;
    scl_lo <= 1'b1;
  endtask

  // Start or repeated start
  task automatic start();
    tick(2);
    sda_lo <= 1'b0;
    tick(2);
    rise();
    sda_lo <= 1'b1;
    tick(3);
    scl_lo <= 1'b1;
  endtask

  task automatic stop();
    tick(2);
    sda_lo <= 1'b1;
    tick(2);
    rise();
    sda_lo <= 1'b0;
    tick(8);
  endtask

  // Byte out, acknowledge back
  task automatic wb(input logic [7:0] b, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ak = ~s;
  endtask

  // Byte in, host answers ack or nack
  task automatic rb(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(nak, s);
  endtask
endmodule

/* File: verification/pmbti_top_tb_top.sv */
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD at %0t got %h exp %h", $time, (a), (e)); end end

module pmbti_top_tb_top import pmbti_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int         TO  = 2000;
  localparam logic [6:0] ADR = 7'h25;

  logic        mclk, nrst, hsel, hwrite, hreadyout, scl, sda;
  logic        scl_oe, sda_oe, al_oe, en_pin, sense_en, iout_stb, conv_on;
  logic        hresp, scl_o, sda_o, al_o;
  logic [1:0]  htrans;
  logic [2:0]  hsize, strap_hi;
  logic [3:0]  strap_lo;
  logic [7:0]  evt_in;
  logic [10:0] m_iout, m_vin, m_temp, m_freq;
  logic [15:0] m_vout;
  logic [31:0] haddr, hwdata, hrdata;
  int          mismatches, n_checks, n_stretch;

  pmbti_top #(.TOUT(TO)) dut (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(scl),
    .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o),
    .sda_oe(sda_oe), .alert_out_line_out(al_o), .alert_out_line_oe(al_oe),
    .enable_pin_in(en_pin), .address_strap_pins_hi(strap_hi),
    .address_strap_pins_lo(strap_lo), .strap_sense_en(sense_en),
    .evt_in(evt_in), .iout_stb(iout_stb), .meas_iout(m_iout),
    .meas_vout(m_vout), .meas_vin(m_vin), .meas_temp(m_temp),
    .meas_freq_khz(m_freq), .conv_on(conv_on));

  pmbti_host_model host (.mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));

  // 10 MHz clock and stretch counter
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (scl_oe === 1'b1) n_stretch++;

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction

  // One single-word transfer, waits on hready
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge mclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    k = 0;
    do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    k = 0;
    do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    rd = hrdata;
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask

  task automatic send(input logic [7:0] b, inout logic [7:0] c);
    logic ak;
    host.wb(b, ak);
    c = crc8(c, b);
    `CHK(ak, 1'b1)
  endtask

  // Full PMBus write or read with error-check byte
  task automatic pm(input logic rd, input logic [7:0] cmd, input int n,
                    input logic [15:0] wv, input logic bad,
                    output logic [15:0] rv);
    logic [7:0] c, b;
    c = 8'h00;
    rv = 16'h0;
    host.start();
    send({ADR, 1'b0}, c);
    send(cmd, c);
    if (rd) begin
      host.start();
      send({ADR, 1'b1}, c);
      for (int i = 0; i < n; i++) begin
        host.rb(1'b0, b);
        rv[8*i +: 8] = b;
        c = crc8(c, b);
      end
      host.rb(1'b1, b);
      `CHK(b, c)
    end else begin
      for (int i = 0; i < n; i++) send(wv[8*i +: 8], c);
      send(c ^ {7'h0, bad}, c);
    end
    host.stop();
    host.tick(5);
  endtask

  task automatic t_reset();
    `CHK(sense_en, 1'b0)
    reg_is(REG_ALERT_EN, 32'h0000_00ff);
    reg_is(REG_ADDR, {25'h0, ADR});
    reg_is(REG_ONOFF, 32'h0001_0016);
    reg_is(8'h40, 32'h0);
    `CHK({hresp, scl_o, sda_o, al_o}, 4'h0)
    strap_hi <= 3'h0;
    strap_lo <= 4'h0;
    reg_is(REG_ADDR, {25'h0, ADR});
  endtask

  task automatic t_onoff();
    logic [15:0] v;
    pm(1'b0, CMD_OPERATION, 1, 16'h0000, 1'b0, v);
    `CHK(conv_on, 1'b1)
    en_pin <= 1'b0;
    host.tick(10);
    `CHK(conv_on, 1'b0)
    pm(1'b0, CMD_ONOFF, 1, 16'h001a, 1'b0, v);
    pm(1'b0, CMD_OPERATION, 1, 16'h0080, 1'b0, v);
    `CHK(conv_on, 1'b1)
    reg_is(REG_ONOFF, 32'h0001_801a);
    pm(1'b0, CMD_OPERATION, 1, 16'h0000, 1'b1, v);
    `CHK(conv_on, 1'b1)
  endtask

  task automatic t_alert();
    logic [31:0] r;
    logic [15:0] v;
    evt_in <= 8'h20;
    host.tick(1);
    evt_in <= 8'h00;
    host.tick(4);
    `CHK(al_oe, 1'b1)
    `CHK(conv_on, 1'b1)
    evt_in <= 8'h01;
    host.tick(1);
    evt_in <= 8'h00;
    host.tick(4);
    `CHK(conv_on, 1'b0)
    reg_is(REG_STATUS, 32'h0000_0021);
    ahb(1'b1, REG_ALERT_EN, 32'h0000_00de, r);
    host.tick(3);
    `CHK(al_oe, 1'b0)
    ahb(1'b1, REG_ALERT_EN, 32'h0000_00fe, r);
    host.tick(3);
    `CHK(al_oe, 1'b1)
    pm(1'b0, CMD_CLRF, 0, 16'h0, 1'b0, v);
    reg_is(REG_STATUS, 32'h0);
    `CHK({al_oe, conv_on}, 2'b01)
  endtask

  task automatic t_telem();
    logic [15:0] v;
    iout_stb <= 1'b1;
    host.tick(1);
    iout_stb <= 1'b0;
    pm(1'b1, CMD_RD_IOUT, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_IOUT, 11'h012})
    repeat (200) begin
      iout_stb <= 1'b1;
      host.tick(1);
      iout_stb <= 1'b0;
      host.tick(1);
    end
    pm(1'b1, CMD_RD_IOUT, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_IOUT, 11'h123})
    pm(1'b1, CMD_RD_VIN, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_VIN, 11'h2a5})
    pm(1'b1, CMD_RD_TEMP2, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_TEMP, 11'h019})
    pm(1'b1, CMD_RD_FREQ, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_FREQ, 11'h1f4})
    pm(1'b1, CMD_RD_VOUT, 2, 16'h0, 1'b0, v);
    `CHK(v, 16'h0432)
    pm(1'b0, CMD_VOUT_MODE, 1, 16'h0017, 1'b0, v);
    pm(1'b1, CMD_RD_VOUT, 2, 16'h0, 1'b0, v);
    `CHK(v, 16'h0086)
    // Fresh measurements, one zero current sample
    m_vin    <= 11'h3c1;
    m_temp   <= 11'h07e;
    m_freq   <= 11'h258;
    m_vout   <= 16'h8642;
    m_iout   <= 11'h000;
    iout_stb <= 1'b1;
    host.tick(1);
    iout_stb <= 1'b0;
    pm(1'b1, CMD_RD_IOUT, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_IOUT, 11'h110})
    pm(1'b1, CMD_RD_VIN, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_VIN, 11'h3c1})
    pm(1'b1, CMD_RD_TEMP2, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_TEMP, 11'h07e})
    pm(1'b1, CMD_RD_FREQ, 2, 16'h0, 1'b0, v);
    `CHK(v, {EXP_FREQ, 11'h258})
    pm(1'b1, CMD_RD_VOUT, 2, 16'h0, 1'b0, v);
    `CHK(v, 16'h010c)
  endtask

  task automatic t_errors();
    logic [7:0]  c;
    logic [15:0] v;
    logic        ak;
    host.start();
    host.wb({ADR ^ 7'h01, 1'b0}, ak);
    `CHK(ak, 1'b0)
    host.stop();
    c = 8'h00;
    host.start();
    send({ADR, 1'b0}, c);
    send(CMD_STATUS, c);
    host.start();
    send({ADR, 1'b1}, c);
    host.tick(10);
    `CHK(sda_oe, 1'b1)
    host.tick(TO + 100);
    `CHK(sda_oe, 1'b0)
    host.stop();
    pm(1'b1, CMD_VOUT_MODE, 1, 16'h0, 1'b0, v);
    `CHK(v, 16'h0017)
  endtask

  // Watchdog against a hung bus
  initial begin
    repeat (80000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {mclk, nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {evt_in, iout_stb, en_pin} = 10'h001;
    {strap_hi, strap_lo, hsize} = {ADR, 3'h2};
    {m_iout, m_vin, m_temp, m_freq} = {11'h123, 11'h2a5, 11'h019, 11'h1f4};
    m_vout = 16'h4321;
    repeat (10) @(posedge mclk);
    `CHK(sense_en, 1'b1)
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (30) @(posedge mclk);
    t_reset();
    t_onoff();
    t_alert();
    t_telem();
    t_errors();
    `CHK(n_stretch > 0, 1'b1)
    give_verdict();
  end
endmodule
